// File: lsf_pkg.sv
// Purpose: shared constants for the link status flag unit
// Assumes: one word address space, link regions laid side by side
// Notes:   word offsets are relative to the start of a link's region
package lsf_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int MAX_LINKS = 12;
  localparam int NUM_BLOCKS = 128;
  localparam int WORD_BITS = 16;
  localparam int ARRAY_WORDS = NUM_BLOCKS / WORD_BITS;
  localparam int ADDR_BITS = 13;

  // ----------------------------------------------------------------
  // word layout inside one link region
  // ----------------------------------------------------------------
  localparam int LINK_STRIDE = 500;
  localparam int WORD_LINK_FLAGS = 0;
  localparam int BIT_ALL_OK = 0;
  localparam int BIT_TROUBLE = 1;
  localparam int BIT_ENABLED = 2;
  localparam int WORD_RUN_MODE = 10;
  localparam int WORD_GENERAL_STATE = 18;
  localparam int WORD_COMM_OK = 26;
  localparam int WORD_ERROR = 34;
  localparam int WORD_CONFIGURED = 42;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [WORD_BITS-1:0] RST_RD_DATA = 16'h0000;
  localparam logic [NUM_BLOCKS-1:0] RST_BLOCK_BITS = 128'h0;

  // ----------------------------------------------------------------
  // per-link flag state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LSF_DISABLED = 2'b00,
    LSF_WAITING = 2'b01,
    LSF_RUNNING = 2'b10
  } lsf_state_t;

endpackage

// File: lsf_link.sv
// Purpose: flag logic for one cyclic data link
// Assumes: block inputs come from link logic on the same clock
// Notes:   all flags are registered; enabled is one cycle behind its request, ok and trouble two behind block inputs
`timescale 1ns/1ps
module lsf_link (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic enable_req,
  input wire logic station_param_ok,
  // block status from the link engine
  input wire logic [lsf_pkg::NUM_BLOCKS-1:0] run_mode_in,
  input wire logic [lsf_pkg::NUM_BLOCKS-1:0] comm_ok_in,
  input wire logic [lsf_pkg::NUM_BLOCKS-1:0] error_in,
  input wire logic [lsf_pkg::NUM_BLOCKS-1:0] configured_in,
  // flags
  output logic enabled_state,
  output logic all_stations_ok_flag,
  output logic link_fault_indication_flag,
  output logic [lsf_pkg::NUM_BLOCKS-1:0] block_run_mode_bit,
  output logic [lsf_pkg::NUM_BLOCKS-1:0] block_comm_ok_bit,
  output logic [lsf_pkg::NUM_BLOCKS-1:0] block_error_bit,
  output logic [lsf_pkg::NUM_BLOCKS-1:0] block_configured_bit,
  output logic [lsf_pkg::NUM_BLOCKS-1:0] block_general_state
);

  lsf_pkg::lsf_state_t state;
  lsf_pkg::lsf_state_t next_state;
  logic next_trouble;
  logic healthy;
  logic faulty;

  // ----------------------------------------------------------------
  // health terms, taken from the registered arrays
  // ----------------------------------------------------------------
  // an empty configuration is never called healthy
  assign healthy = station_param_ok && (|block_configured_bit) &&
                   ((block_configured_bit & ~(block_run_mode_bit & block_comm_ok_bit & ~block_error_bit))
                    == lsf_pkg::RST_BLOCK_BITS);
  assign faulty = |(block_configured_bit & (~block_run_mode_bit | block_error_bit | ~block_comm_ok_bit));

  // ----------------------------------------------------------------
  // link state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      lsf_pkg::LSF_DISABLED: begin
        if (enable_req) begin
          next_state = lsf_pkg::LSF_WAITING;
        end
      end
      lsf_pkg::LSF_WAITING: begin
        if (!enable_req) begin
          next_state = lsf_pkg::LSF_DISABLED;
        end else if (healthy) begin
          next_state = lsf_pkg::LSF_RUNNING;
        end
      end
      lsf_pkg::LSF_RUNNING: begin
        // later faults do not drop the flag, only a stop does
        if (!enable_req) begin
          next_state = lsf_pkg::LSF_DISABLED;
        end
      end
      default: begin
        next_state = lsf_pkg::LSF_DISABLED;
      end
    endcase
    next_trouble = (next_state == lsf_pkg::LSF_RUNNING) && (state == lsf_pkg::LSF_RUNNING) && faulty;
  end

  // flags get their own flops so the top outputs come straight from registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= lsf_pkg::LSF_DISABLED;
      link_fault_indication_flag <= 1'b0;
      enabled_state <= 1'b0;
      all_stations_ok_flag <= 1'b0;
    end else begin
      state <= next_state;
      link_fault_indication_flag <= next_trouble;
      enabled_state <= (next_state != lsf_pkg::LSF_DISABLED);
      all_stations_ok_flag <= (next_state == lsf_pkg::LSF_RUNNING);
    end
  end

  // ----------------------------------------------------------------
  // per-block arrays
  // ----------------------------------------------------------------
  logic [lsf_pkg::NUM_BLOCKS-1:0] next_general;

  always_comb begin
    next_general = run_mode_in & comm_ok_in & ~error_in;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      block_run_mode_bit <= lsf_pkg::RST_BLOCK_BITS;
      block_comm_ok_bit <= lsf_pkg::RST_BLOCK_BITS;
      block_error_bit <= lsf_pkg::RST_BLOCK_BITS;
      block_configured_bit <= lsf_pkg::RST_BLOCK_BITS;
      block_general_state <= lsf_pkg::RST_BLOCK_BITS;
    end else begin
      block_run_mode_bit <= run_mode_in;
      block_comm_ok_bit <= comm_ok_in;
      block_error_bit <= error_in;
      block_configured_bit <= configured_in;
      block_general_state <= next_general;
    end
  end

endmodule // lsf_link

// File: lsf_top.sv
// What this block does
// - A link's all-stations-ok flag sets only when every configured block runs without error, communicates, and station parameters are good.
// - Once set, the all-stations-ok flag stays set until that link's enable request is withdrawn.
// - While all-stations-ok is set, the trouble flag rises on a configured block not running, in error or not communicating.
// - The trouble flag clears as soon as none of those conditions remains.
// - Each block's general state is run mode AND communication ok AND NOT error, for blocks 0 to 127.
// - One communication-ok bit is kept per block.
// - One error bit is kept per block.
// - One configured bit is kept per block.
// - Each 128-bit array is packed into eight 16-bit words, lowest blocks first.
// - The run-mode array of a link starts at word 10 and runs through word 17.
// - A link's region starts at 500 times its number minus one, all links alike.
// - Each link from 1 to 12 has its own independent flag set.
// - Each link is enabled by its own request bit and reports its enabled state on its own bit.
//
// Purpose: status flag unit for up to twelve cyclic data links
// Assumes: all inputs come from logic on REF_CLK, so none is synchronised
// Notes:   reads return one cycle after the address is presented
`timescale 1ns/1ps
module lsf_top #(
  parameter int NUM_LINKS = 12
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // link control
  input wire logic [NUM_LINKS-1:0] LINK_ENABLE_REQUEST,
  input wire logic [NUM_LINKS-1:0] STATION_PARAM_OK,
  // block status, link l occupies bits [l*128 +: 128]
  input wire logic [NUM_LINKS*lsf_pkg::NUM_BLOCKS-1:0] BLOCK_RUN_MODE_IN,
  input wire logic [NUM_LINKS*lsf_pkg::NUM_BLOCKS-1:0] BLOCK_COMM_OK_IN,
  input wire logic [NUM_LINKS*lsf_pkg::NUM_BLOCKS-1:0] BLOCK_ERROR_IN,
  input wire logic [NUM_LINKS*lsf_pkg::NUM_BLOCKS-1:0] BLOCK_CONFIGURED_IN,
  // link flags
  output logic [NUM_LINKS-1:0] LINK_ENABLED_STATE,
  output logic [NUM_LINKS-1:0] ALL_STATIONS_OK_FLAG,
  output logic [NUM_LINKS-1:0] LINK_FAULT_INDICATION_FLAG,
  // word read port
  input wire logic [lsf_pkg::ADDR_BITS-1:0] RD_ADDR,
  output logic [lsf_pkg::WORD_BITS-1:0] RD_DATA
);

  localparam int NB = lsf_pkg::NUM_BLOCKS;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NUM_LINKS < 1 || NUM_LINKS > lsf_pkg::MAX_LINKS) begin : g_bad_links
    $error("lsf_top: NUM_LINKS must be 1 to 12");
  end

  // ----------------------------------------------------------------
  // one flag set per link
  // ----------------------------------------------------------------
  logic [NUM_LINKS*NB-1:0] run_mode_arr;
  logic [NUM_LINKS*NB-1:0] comm_ok_arr;
  logic [NUM_LINKS*NB-1:0] error_arr;
  logic [NUM_LINKS*NB-1:0] configured_arr;
  logic [NUM_LINKS*NB-1:0] general_arr;

  for (genvar l = 0; l < NUM_LINKS; l++) begin : g_link
    lsf_link u_link (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .enable_req(LINK_ENABLE_REQUEST[l]),
      .station_param_ok(STATION_PARAM_OK[l]),
      .run_mode_in(BLOCK_RUN_MODE_IN[l*NB +: NB]),
      .comm_ok_in(BLOCK_COMM_OK_IN[l*NB +: NB]),
      .error_in(BLOCK_ERROR_IN[l*NB +: NB]),
      .configured_in(BLOCK_CONFIGURED_IN[l*NB +: NB]),
      .enabled_state(LINK_ENABLED_STATE[l]),
      .all_stations_ok_flag(ALL_STATIONS_OK_FLAG[l]),
      .link_fault_indication_flag(LINK_FAULT_INDICATION_FLAG[l]),
      .block_run_mode_bit(run_mode_arr[l*NB +: NB]),
      .block_comm_ok_bit(comm_ok_arr[l*NB +: NB]),
      .block_error_bit(error_arr[l*NB +: NB]),
      .block_configured_bit(configured_arr[l*NB +: NB]),
      .block_general_state(general_arr[l*NB +: NB])
    );
  end

  // ----------------------------------------------------------------
  // word read decode
  // ----------------------------------------------------------------
  logic [lsf_pkg::WORD_BITS-1:0] next_rd_data;

  // a 16-block slice of one array, word w of that array
  function automatic logic [lsf_pkg::WORD_BITS-1:0] pick(input logic [NB-1:0] arr, input int w);
    pick = arr[w*lsf_pkg::WORD_BITS +: lsf_pkg::WORD_BITS];
  endfunction

  // linear search beats a divide by 500 for only twelve regions
  always_comb begin
    int off;
    int w;
    next_rd_data = lsf_pkg::RST_RD_DATA;
    off = 0;
    w = 0;
    for (int l = 0; l < NUM_LINKS; l++) begin
      if (int'(RD_ADDR) >= l * lsf_pkg::LINK_STRIDE && int'(RD_ADDR) < (l + 1) * lsf_pkg::LINK_STRIDE) begin
        off = int'(RD_ADDR) - l * lsf_pkg::LINK_STRIDE;
        if (off == lsf_pkg::WORD_LINK_FLAGS) begin
          next_rd_data[lsf_pkg::BIT_ALL_OK] = ALL_STATIONS_OK_FLAG[l];
          next_rd_data[lsf_pkg::BIT_TROUBLE] = LINK_FAULT_INDICATION_FLAG[l];
          next_rd_data[lsf_pkg::BIT_ENABLED] = LINK_ENABLED_STATE[l];
        end else if (off >= lsf_pkg::WORD_RUN_MODE && off < lsf_pkg::WORD_RUN_MODE + lsf_pkg::ARRAY_WORDS) begin
          w = off - lsf_pkg::WORD_RUN_MODE;
          next_rd_data = pick(run_mode_arr[l*NB +: NB], w);
        end else if (off >= lsf_pkg::WORD_GENERAL_STATE &&
                     off < lsf_pkg::WORD_GENERAL_STATE + lsf_pkg::ARRAY_WORDS) begin
          w = off - lsf_pkg::WORD_GENERAL_STATE;
          next_rd_data = pick(general_arr[l*NB +: NB], w);
        end else if (off >= lsf_pkg::WORD_COMM_OK && off < lsf_pkg::WORD_COMM_OK + lsf_pkg::ARRAY_WORDS) begin
          w = off - lsf_pkg::WORD_COMM_OK;
          next_rd_data = pick(comm_ok_arr[l*NB +: NB], w);
        end else if (off >= lsf_pkg::WORD_ERROR && off < lsf_pkg::WORD_ERROR + lsf_pkg::ARRAY_WORDS) begin
          w = off - lsf_pkg::WORD_ERROR;
          next_rd_data = pick(error_arr[l*NB +: NB], w);
        end else if (off >= lsf_pkg::WORD_CONFIGURED &&
                     off < lsf_pkg::WORD_CONFIGURED + lsf_pkg::ARRAY_WORDS) begin
          w = off - lsf_pkg::WORD_CONFIGURED;
          next_rd_data = pick(configured_arr[l*NB +: NB], w);
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA <= lsf_pkg::RST_RD_DATA;
    end else begin
      RD_DATA <= next_rd_data;
    end
  end

endmodule // lsf_top

// File: lsf_station_model.sv
// Purpose: remote stations behind the links, as block status levels
// Assumes: blocks 0..63 are configured on a link whose cfg_on is high
// Notes:   unconfigured blocks report neither run nor comm, so they read as idle
`timescale 1ns/1ps
module lsf_station_model #(
  parameter int NL = 2
) (
  // configuration
  input wire logic [NL-1:0] cfg_on,
  // fault injection: 1 not running, 2 error, 3 poor exchange
  input wire logic [1:0] fault_code,
  input wire logic [3:0] fault_link,
  input wire logic [6:0] fault_blk,
  // block status
  output logic [NL*128-1:0] run,
  output logic [NL*128-1:0] comm,
  output logic [NL*128-1:0] err,
  output logic [NL*128-1:0] cfg
);
  always_comb begin
    for (int l = 0; l < NL; l++) begin
      for (int k = 0; k < 128; k++) begin
        cfg[l*128+k] = cfg_on[l] && k < 64;
        run[l*128+k] = cfg[l*128+k] && !(fault_code == 2'h1 && l == fault_link && k == fault_blk);
        comm[l*128+k] = cfg[l*128+k] && !(fault_code == 2'h3 && l == fault_link && k == fault_blk);
        // errors may be raised on unconfigured blocks too
        err[l*128+k] = fault_code == 2'h2 && l == fault_link && k == fault_blk;
      end
    end
  end
endmodule // lsf_station_model

// File: lsf_top_properties.sv
// Purpose: port checks of the flag unit on link 0 and the read port
// Assumes: all links share one logic, so link 0 stands for them
// Notes:   bound into lsf_top
`timescale 1ns/1ps
module lsf_chk #(
  parameter int NUM_LINKS = 12
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // inputs
  input wire logic [NUM_LINKS-1:0] LINK_ENABLE_REQUEST,
  input wire logic [NUM_LINKS-1:0] STATION_PARAM_OK,
  input wire logic [NUM_LINKS*lsf_pkg::NUM_BLOCKS-1:0] BLOCK_RUN_MODE_IN,
  input wire logic [NUM_LINKS*lsf_pkg::NUM_BLOCKS-1:0] BLOCK_COMM_OK_IN,
  input wire logic [NUM_LINKS*lsf_pkg::NUM_BLOCKS-1:0] BLOCK_ERROR_IN,
  input wire logic [NUM_LINKS*lsf_pkg::NUM_BLOCKS-1:0] BLOCK_CONFIGURED_IN,
  input wire logic [lsf_pkg::ADDR_BITS-1:0] RD_ADDR,
  // outputs
  input wire logic [NUM_LINKS-1:0] LINK_ENABLED_STATE,
  input wire logic [NUM_LINKS-1:0] ALL_STATIONS_OK_FLAG,
  input wire logic [NUM_LINKS-1:0] LINK_FAULT_INDICATION_FLAG,
  input wire logic [lsf_pkg::WORD_BITS-1:0] RD_DATA
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic fault0;
  logic [15:0] gen0;
  assign fault0 = |(BLOCK_CONFIGURED_IN[127:0] & (~BLOCK_RUN_MODE_IN[127:0] | BLOCK_ERROR_IN[127:0]
                  | ~BLOCK_COMM_OK_IN[127:0]));
  assign gen0 = BLOCK_RUN_MODE_IN[15:0] & BLOCK_COMM_OK_IN[15:0] & ~BLOCK_ERROR_IN[15:0];
  AST_ENABLE: assert property (LINK_ENABLE_REQUEST[0] |=> LINK_ENABLED_STATE[0]) else $error("enable lost");
  AST_STOP: assert property (!LINK_ENABLE_REQUEST[0] |=> !(LINK_ENABLED_STATE[0] | ALL_STATIONS_OK_FLAG[0]
    | LINK_FAULT_INDICATION_FLAG[0])) else $error("stop ignored");
  AST_OK_HOLD: assert property (ALL_STATIONS_OK_FLAG[0] && LINK_ENABLE_REQUEST[0] |=> ALL_STATIONS_OK_FLAG[0])
    else $error("ok dropped");
  AST_OK_CAUSE: assert property ($rose(ALL_STATIONS_OK_FLAG[0]) |-> !$past(fault0, 2)
    && $past(|BLOCK_CONFIGURED_IN[127:0], 2) && $past(LINK_ENABLED_STATE[0])
    && $past(STATION_PARAM_OK[0])) else $error("ok unjustified");
  AST_TRB_NEEDS_OK: assert property ($rose(LINK_FAULT_INDICATION_FLAG[0]) |-> $past(ALL_STATIONS_OK_FLAG[0]))
    else $error("trouble without ok");
  AST_TRB_RAISE: assert property (fault0 && ALL_STATIONS_OK_FLAG[0] && LINK_ENABLE_REQUEST[0]
    ##1 LINK_ENABLE_REQUEST[0] |=> LINK_FAULT_INDICATION_FLAG[0]) else $error("trouble missed");
  AST_TRB_CLEAR: assert property (!fault0 |=> ##1 !LINK_FAULT_INDICATION_FLAG[0]) else $error("trouble stuck");
  AST_GEN_WORD: assert property (RD_ADDR == 13'h012 && $past(RST_N) |=> RD_DATA == $past(gen0, 2))
    else $error("general state word wrong");
  AST_UNMAPPED: assert property (RD_ADDR == 13'h003 |=> RD_DATA == 16'h0000) else $error("unmapped not zero");
  cover property ($rose(ALL_STATIONS_OK_FLAG[0]));
  cover property ($rose(LINK_FAULT_INDICATION_FLAG[0]));
  cover property ($fell(LINK_ENABLED_STATE[0]));
endmodule // lsf_chk

bind lsf_top lsf_chk #(.NUM_LINKS(NUM_LINKS)) u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .LINK_ENABLE_REQUEST(LINK_ENABLE_REQUEST), .STATION_PARAM_OK(STATION_PARAM_OK), .BLOCK_RUN_MODE_IN(BLOCK_RUN_MODE_IN),
  .BLOCK_COMM_OK_IN(BLOCK_COMM_OK_IN), .BLOCK_ERROR_IN(BLOCK_ERROR_IN), .BLOCK_CONFIGURED_IN(BLOCK_CONFIGURED_IN),
  .RD_ADDR(RD_ADDR), .LINK_ENABLED_STATE(LINK_ENABLED_STATE), .ALL_STATIONS_OK_FLAG(ALL_STATIONS_OK_FLAG),
  .LINK_FAULT_INDICATION_FLAG(LINK_FAULT_INDICATION_FLAG), .RD_DATA(RD_DATA));

// File: link_status_flag_unit_test.sv
// Purpose: self-checking bench of the flag unit with two links
// Assumes: flag and read latencies as handed over
// Notes:   faults are injected on link 0, block 55 or 100
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module link_status_flag_unit_test;
  typedef struct {logic [1:0] fc; logic [6:0] blk; logic [12:0] addr; logic [15:0] exp;} lsf_row_t;
  logic REF_CLK = 0;
  logic RST_N = 0;
  logic [1:0] req = 2'h0;
  logic [1:0] param = 2'h1;
  logic [1:0] cfg_on = 2'h3;
  logic [1:0] fc = 2'h0;
  logic [6:0] fblk = 7'h00;
  logic [12:0] RD_ADDR = 13'h000;
  logic [255:0] run, comm, err, cfg;
  logic [1:0] enabled, ok, trouble;
  logic [15:0] RD_DATA;
  lsf_row_t rows [16];
  int errors = 0;
  int total_checks = 0;
  int i;
  always #4 REF_CLK = ~REF_CLK;
  lsf_station_model #(.NL(2)) stations (.cfg_on(cfg_on), .fault_code(fc), .fault_link(4'h0), .fault_blk(fblk),
    .run(run), .comm(comm), .err(err), .cfg(cfg));
  lsf_top #(.NUM_LINKS(2)) dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .LINK_ENABLE_REQUEST(req), .STATION_PARAM_OK(param),
    .BLOCK_RUN_MODE_IN(run), .BLOCK_COMM_OK_IN(comm), .BLOCK_ERROR_IN(err), .BLOCK_CONFIGURED_IN(cfg),
    .LINK_ENABLED_STATE(enabled), .ALL_STATIONS_OK_FLAG(ok), .LINK_FAULT_INDICATION_FLAG(trouble), .RD_ADDR(RD_ADDR),
    .RD_DATA(RD_DATA));
  task results;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task settle(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask
  task rd(input logic [12:0] a, input logic [15:0] e);
    @(negedge REF_CLK);
    RD_ADDR = a;
    @(negedge REF_CLK);
    `CHK(RD_DATA, e)
  endtask
  initial begin
    rows = '{'{2'h0, 7'h00, 13'h000, 16'h0005}, '{2'h0, 7'h00, 13'h00d, 16'hffff}, '{2'h0, 7'h00, 13'h02d, 16'hffff},
      '{2'h0, 7'h00, 13'h02e, 16'h0000}, '{2'h1, 7'h37, 13'h00d, 16'hff7f}, '{2'h1, 7'h37, 13'h000, 16'h0007},
      '{2'h2, 7'h37, 13'h025, 16'h0080}, '{2'h2, 7'h37, 13'h015, 16'hff7f}, '{2'h3, 7'h37, 13'h01d, 16'hff7f},
      '{2'h3, 7'h37, 13'h000, 16'h0007}, '{2'h2, 7'h64, 13'h028, 16'h0010}, '{2'h2, 7'h64, 13'h000, 16'h0005},
      '{2'h0, 7'h00, 13'h000, 16'h0005}, '{2'h0, 7'h00, 13'h003, 16'h0000}, '{2'h0, 7'h00, 13'h1f4, 16'h0000},
      '{2'h0, 7'h00, 13'h012, 16'hffff}};
    settle(10);
    `CHK({enabled, ok, trouble, RD_DATA}, 22'h0)
    RST_N = 1;
    $display("reset test done");
    req = 2'h1;
    for (i = 0; i < 10 && ok[0] !== 1'b1; i++) settle(1);
    if (i == 10) begin
      errors++;
      results();
    end
    foreach (rows[j]) begin
      fc = rows[j].fc;
      fblk = rows[j].blk;
      settle(3);
      rd(rows[j].addr, rows[j].exp);
    end
    $display("table test done");
    // link 2 waits for its station parameters
    req = 2'h3;
    settle(4);
    rd(13'h1f4, 16'h0004);
    param = 2'h3;
    settle(4);
    rd(13'h1f4, 16'h0005);
    rd(13'h201, 16'hffff);
    // no configured block, no ok
    cfg_on = 2'h1;
    req = 2'h1;
    settle(2);
    req = 2'h3;
    settle(4);
    rd(13'h1f4, 16'h0004);
    $display("link two test done");
    fc = 2'h1;
    fblk = 7'h37;
    settle(3);
    `CHK({ok[0], trouble[0]}, 2'h3)
    req = 2'h2;
    settle(2);
    `CHK({enabled[0], ok[0], trouble[0]}, 3'h0)
    $display("stop test done");
    results();
  end
endmodule // link_status_flag_unit_test
